// *** core/pbr_pkg.sv ***
`default_nettype none
package pbr_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_SW_CFG   = 8'h15;
    localparam logic [7:0] ADDR_BUCK     = 8'h16;
    localparam logic [7:0] SW_CFG_RESET  = 8'h00;
    localparam logic [7:0] BUCK_RESET    = 8'hB5;
    // Writable bits; everything else is reserved and reads zero
    localparam logic [7:0] SW_CFG_WMASK  = 8'h3F;
    localparam logic [7:0] BUCK_WMASK    = 8'hBF;

    // ==========================================================
    // Field positions
    localparam int NUM_SWITCHES  = 3;
    localparam int FAIL_LSB      = 3;
    localparam int DIS_LSB       = 0;
    localparam int SKIP_BIT      = 7;
    localparam int CODE_W        = 6;

    // ==========================================================
    // Voltage code mapping, millivolts
    localparam int MV_W                  = 11;
    localparam logic [10:0] MV_BASE      = 11'h352;
    localparam logic [10:0] MV_STEP_FINE = 11'h00A;
    localparam logic [5:0]  MV_KNEE_CODE = 6'h32;
    localparam logic [10:0] MV_KNEE      = 11'h546;
    localparam logic [10:0] MV_STEP_WIDE = 11'h019;

    // ==========================================================
    // Timing
    localparam int CLK_KHZ        = 20000;
    localparam int BLANK_TIME_US  = 5000;
    localparam int BLANK_CYCLES   = BLANK_TIME_US * CLK_KHZ / 1000;
    localparam int SYNC_BITS      = 3;
    localparam int SYNC_PF        = 0;
    localparam int SYNC_OV        = 1;
    localparam int SYNC_UV        = 2;
endpackage : pbr_pkg
`default_nettype wire

// *** core/pbr_switch_ch.sv ***
`timescale 1ns/100ps
`default_nettype none
module pbr_switch_ch
    import pbr_pkg::*;
(
    input  wire logic clock,         // System clock
    input  wire logic rst,           // Synchronous reset
    input  wire logic switch_en,     // Switch enable from sequencer
    input  wire logic fail_off_en,   // Power fail forces switch off
    input  wire logic discharge_en,  // Pull output down while off
    input  wire logic pf_low,        // Synchronised power fail, active
    output logic      switch_on,     // Switch gate drive
    output logic      discharge_on   // Output discharge drive
);
    logic on_d;
    logic on_q;
    logic dis_d;
    logic dis_q;

    // ==========================================================
    // Next state
    always_comb begin
        on_d  = switch_en & ~(fail_off_en & pf_low);
        dis_d = discharge_en & ~on_d;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            on_q  <= 1'b0;
            dis_q <= 1'b0;
        end else begin
            on_q  <= on_d;
            dis_q <= dis_d;
        end
    end

    assign switch_on    = on_q;
    assign discharge_on = dis_q;
endmodule : pbr_switch_ch
`default_nettype wire

// *** core/pbr_blank_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module pbr_blank_timer #(
    parameter int CYCLES = 100000
) (
    input  wire logic clock,     // System clock
    input  wire logic rst,       // Synchronous reset
    input  wire logic start,     // Restart the interval
    output logic      active     // Interval running
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] count_d;
    logic [CW-1:0] count_q;

    // ==========================================================
    // Countdown; a new start reloads so blanking always covers
    // the full interval after the latest write
    always_comb begin
        count_d = count_q;
        if (start) begin
            count_d = LOAD;
        end else if (count_q != '0) begin
            count_d = count_q - ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign active = (count_q != '0);
endmodule : pbr_blank_timer
`default_nettype wire

// *** core/pbr_regs.sv ***
// Behaviour
// - Both registers accept writes only while the password unlock is satisfied.
// - A switch with fail-off set turns off while the power-fail output is low.
// - A switch with fail-off clear ignores the power-fail output.
// - With discharge enabled, a switch output is pulled down whenever it is off.
// - With discharge disabled, no pull-down is applied to the switch output.
// - Any accepted buck write blanks over- and under-voltage monitoring for 5 ms.
// - A new voltage code reaches the converter only on a commit strobe.
// - Bit 7 enables pulse skipping, resets to one; zero forces fixed frequency.
// - Code maps 0.850 V plus 10 mV steps to 1.350 V, then 25 mV steps.
`timescale 1ns/100ps
`default_nettype none
module pbr_regs
    import pbr_pkg::*;
#(
    parameter int BLANK_CYC = BLANK_CYCLES
) (
    input  wire logic              clock,            // 20 MHz system clock
    input  wire logic              rst,              // Synchronous reset, high
    input  wire logic              wr_en,            // Register write strobe
    input  wire logic [7:0]        wr_addr,          // Write subaddress
    input  wire logic [7:0]        wr_data,          // Write data
    input  wire logic              unlock_ok,        // Password sequence satisfied
    input  wire logic              rd_en,            // Register read strobe
    input  wire logic [7:0]        rd_addr,          // Read subaddress
    output logic [7:0]             rd_data,          // Read data, one cycle later
    output logic                   rd_valid,         // Read data valid pulse
    output logic                   wr_rejected,      // Locked write refused pulse
    input  wire logic              commit,           // Commit strobe, either kind
    input  wire logic [2:0]        switch_en,        // Switch enables from sequencer
    input  wire logic              power_fail_out_n, // Power-fail comparator pin
    input  wire logic              ov_raw,           // Buck over-voltage comparator
    input  wire logic              uv_raw,           // Buck under-voltage comparator
    output logic [2:0]             switch_on,        // Switch gate drives
    output logic [2:0]             discharge_on,     // Switch discharge drives
    output logic                   pulse_skip_en,    // Light-load pulse skipping
    output logic [CODE_W-1:0]      applied_code,     // Committed voltage code
    output logic [MV_W-1:0]        applied_mv,       // Committed target, millivolts
    output logic                   monitor_blank,    // Monitoring suppressed
    output logic                   ov_fault,         // Qualified over-voltage
    output logic                   uv_fault          // Qualified under-voltage
);
    // ==========================================================
    // Checks all run on the one clock and sleep through reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_BITS-1:0] meta_d;
    logic [SYNC_BITS-1:0] meta_q;
    logic [SYNC_BITS-1:0] sync_d;
    logic [SYNC_BITS-1:0] sync_q;

    always_comb begin
        meta_d          = '0;
        meta_d[SYNC_PF] = ~power_fail_out_n;
        meta_d[SYNC_OV] = ov_raw;
        meta_d[SYNC_UV] = uv_raw;
        sync_d          = meta_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    logic pf_low;
    assign pf_low = sync_q[SYNC_PF];

    // ==========================================================
    // Register file
    logic [7:0] sw_cfg_d;
    logic [7:0] sw_cfg_q;
    logic [7:0] buck_d;
    logic [7:0] buck_q;
    logic       hit_sw;
    logic       hit_buck;
    logic       acc_sw;
    logic       acc_buck;
    logic       rej_d;
    logic       rej_q;

    always_comb begin
        hit_sw   = (wr_addr == ADDR_SW_CFG);
        hit_buck = (wr_addr == ADDR_BUCK);
        acc_sw   = wr_en & unlock_ok & hit_sw;
        acc_buck = wr_en & unlock_ok & hit_buck;
        rej_d    = wr_en & ~unlock_ok & (hit_sw | hit_buck);
        sw_cfg_d = sw_cfg_q;
        buck_d   = buck_q;
        if (acc_sw) begin
            sw_cfg_d = wr_data & SW_CFG_WMASK;
        end
        if (acc_buck) begin
            buck_d = wr_data & BUCK_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sw_cfg_q <= SW_CFG_RESET;
            buck_q   <= BUCK_RESET;
            rej_q    <= 1'b0;
        end else begin
            sw_cfg_q <= sw_cfg_d;
            buck_q   <= buck_d;
            rej_q    <= rej_d;
        end
    end

    assign wr_rejected   = rej_q;
    assign pulse_skip_en = buck_q[SKIP_BIT];

    // ==========================================================
    // Read port; reads are not password protected
    logic [7:0] rdat_d;
    logic [7:0] rdat_q;
    logic       rval_q;

    always_comb begin
        rdat_d = rdat_q;
        if (rd_en) begin
            case (rd_addr)
                ADDR_SW_CFG: rdat_d = sw_cfg_q;
                ADDR_BUCK:   rdat_d = buck_q;
                default:     rdat_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdat_q <= 8'h00;
            rval_q <= 1'b0;
        end else begin
            rdat_q <= rdat_d;
            rval_q <= rd_en;
        end
    end

    assign rd_data  = rdat_q;
    assign rd_valid = rval_q;

    // ==========================================================
    // Load switches
    logic [2:0] fail_en;
    logic [2:0] dis_en;

    assign fail_en = sw_cfg_q[FAIL_LSB +: NUM_SWITCHES];
    assign dis_en  = sw_cfg_q[DIS_LSB +: NUM_SWITCHES];

    for (genvar i = 0; i < NUM_SWITCHES; i++) begin : g_sw
        pbr_switch_ch u_ch (
            .clock        (clock),
            .rst          (rst),
            .switch_en    (switch_en[i]),
            .fail_off_en  (fail_en[i]),
            .discharge_en (dis_en[i]),
            .pf_low       (pf_low),
            .switch_on    (switch_on[i]),
            .discharge_on (discharge_on[i])
        );
    end

    // ==========================================================
    // Monitor blanking
    logic blank_act;

    pbr_blank_timer #(
        .CYCLES (BLANK_CYC)
    ) u_blank (
        .clock  (clock),
        .rst    (rst),
        .start  (acc_buck),
        .active (blank_act)
    );

    logic ov_d;
    logic ov_q;
    logic uv_d;
    logic uv_q;

    always_comb begin
        ov_d = sync_q[SYNC_OV] & ~blank_act;
        uv_d = sync_q[SYNC_UV] & ~blank_act;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ov_q <= 1'b0;
            uv_q <= 1'b0;
        end else begin
            ov_q <= ov_d;
            uv_q <= uv_d;
        end
    end

    assign monitor_blank = blank_act;
    assign ov_fault      = ov_q;
    assign uv_fault      = uv_q;

    // ==========================================================
    // Voltage commit; the voltage code is staged, the converter
    // only sees it after commit so several writes land at once
    logic [CODE_W-1:0] code_d;
    logic [CODE_W-1:0] code_q;
    logic [MV_W-1:0]   mv_d;
    logic [MV_W-1:0]   mv_q;
    logic [CODE_W-1:0] new_code;

    always_comb begin
        new_code = buck_q[CODE_W-1:0];
        code_d   = code_q;
        mv_d     = mv_q;
        if (commit) begin
            code_d = new_code;
            if (new_code <= MV_KNEE_CODE) begin
                mv_d = MV_BASE + MV_W'(MV_STEP_FINE * new_code);
            end else begin
                mv_d = MV_KNEE
                     + MV_W'(MV_STEP_WIDE * (new_code - MV_KNEE_CODE));
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            code_q <= BUCK_RESET[CODE_W-1:0];
            mv_q   <= MV_KNEE + MV_W'(MV_STEP_WIDE
                      * (BUCK_RESET[CODE_W-1:0] - MV_KNEE_CODE));
        end else begin
            code_q <= code_d;
            mv_q   <= mv_d;
        end
    end

    assign applied_code = code_q;
    assign applied_mv   = mv_q;

    // ==========================================================
    // Checks
    localparam int BW = $clog2(BLANK_CYC + 1);
    logic [BW-1:0] blank_age_q;

    always_ff @(posedge clock) begin
        if (rst || acc_buck) begin
            blank_age_q <= '0;
        end else if (blank_act) begin
            blank_age_q <= blank_age_q + BW'(1);
        end
    end

    sequence s_locked_write;
        wr_en && !unlock_ok && (hit_sw || hit_buck);
    endsequence

    sequence s_buck_write;
        acc_buck;
    endsequence

    a_locked_write_held: assert property (
        s_locked_write |=> $stable(sw_cfg_q) && $stable(buck_q) && wr_rejected)
        else $error("locked write changed a register");

    a_fail_forces_off: assert property (
        pf_low |=> ((switch_on & $past(fail_en)) == 3'h0))
        else $error("switch stayed on during power fail");

    a_switch_follows: assert property (
        1'b1 |=> (((switch_on ^ $past(switch_en)) & ~$past(fail_en)) == 3'h0))
        else $error("unguarded switch moved with power fail");

    a_discharge_when_off: assert property (
        1'b1 |=> ((~switch_on & $past(dis_en) & ~discharge_on) == 3'h0))
        else $error("off switch not discharged");

    a_discharge_disabled: assert property (
        1'b1 |=> ((discharge_on & (~$past(dis_en) | switch_on)) == 3'h0))
        else $error("discharge applied when not allowed");

    // Fault flops are registered, so masking shows one cycle after blank rises
    a_blank_starts: assert property (
        s_buck_write |=> monitor_blank ##1 (!ov_fault && !uv_fault))
        else $error("blanking did not start");

    a_blank_length: assert property (
        blank_act && !acc_buck && blank_age_q == BW'(BLANK_CYC - 1)
        |=> !blank_act)
        else $error("blanking outlasted its interval");

    a_commit_only: assert property (
        !commit |=> $stable(applied_code) && $stable(applied_mv))
        else $error("voltage changed without commit");

    a_commit_takes: assert property (
        commit |=> applied_code == $past(buck_q[CODE_W-1:0]))
        else $error("commit did not apply code");

    a_mv_map: assert property (
        commit && buck_q[CODE_W-1:0] == 6'h3F |=> applied_mv == 11'h68B)
        else $error("top code maps wrong");

    a_skip_write: assert property (
        acc_buck |=> pulse_skip_en == $past(wr_data[SKIP_BIT]))
        else $error("pulse skip not written");

    a_reserved_zero: assert property (
        1'b1 |-> (sw_cfg_q & ~SW_CFG_WMASK) == 8'h00
                 && (buck_q & ~BUCK_WMASK) == 8'h00)
        else $error("reserved bit set");

endmodule : pbr_regs
`default_nettype wire

// *** sim/pbr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module pbr_host (
    input  wire logic       clock,     // System clock
    output logic            wr_en,     // Write strobe
    output logic [7:0]      wr_addr,   // Write subaddress
    output logic [7:0]      wr_data,   // Write data
    output logic            unlock_ok, // Password state
    output logic            rd_en,     // Read strobe
    output logic [7:0]      rd_addr,   // Read subaddress
    output logic            commit,    // Commit strobe
    input  wire logic [7:0] rd_data,   // Read data
    input  wire logic       rd_valid   // Read data valid
);
    initial begin
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        unlock_ok = 1'b0;
        rd_en = 1'b0;
        rd_addr = 8'h00;
        commit = 1'b0;
    end

    // ==========================================================
    // Bus cycles
    // Unlock rides with its own write only, so a stale unlock never covers the next one
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        unlock_ok <= ok;
        @(posedge clock);
        wr_en <= 1'b0;
        unlock_ok <= 1'b0;
        wr_data <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(posedge clock);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        for (n = 0; n < 4 && !ok; n++) begin
            #1;
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end else begin
                @(posedge clock);
            end
        end
    endtask

    task automatic cm();
        @(posedge clock);
        commit <= 1'b1;
        @(posedge clock);
        commit <= 1'b0;
    endtask
endmodule // pbr_host
`default_nettype wire

// *** sim/tb_pbr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end
module tb_pbr_regs;
    import pbr_pkg::*;
    localparam int BLANK = 20;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              wr_en, unlock_ok, rd_en, rd_valid, wr_rejected, commit;
    logic [7:0]        wr_addr, wr_data, rd_addr, rd_data, d;
    logic [2:0]        switch_en = 3'h0;
    logic              power_fail_out_n = 1'b1;
    logic              ov_raw = 1'b0;
    logic              uv_raw = 1'b0;
    logic [2:0]        switch_on, discharge_on;
    logic              pulse_skip_en, monitor_blank, ov_fault, uv_fault, ok;
    logic [CODE_W-1:0] applied_code;
    logic [MV_W-1:0]   applied_mv;
    int                err_count = 0;
    int                samples_checked = 0;

    always #25 clock = ~clock;

    pbr_regs #(.BLANK_CYC(BLANK)) pbr_regs_i (.clock(clock), .rst(rst), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .unlock_ok(unlock_ok), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_rejected(wr_rejected), .commit(commit), .switch_en(switch_en),
        .power_fail_out_n(power_fail_out_n), .ov_raw(ov_raw), .uv_raw(uv_raw),
        .switch_on(switch_on), .discharge_on(discharge_on), .pulse_skip_en(pulse_skip_en),
        .applied_code(applied_code), .applied_mv(applied_mv),
        .monitor_blank(monitor_blank), .ov_fault(ov_fault), .uv_fault(uv_fault));

    pbr_host pbr_host_i (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .unlock_ok(unlock_ok), .rd_en(rd_en), .rd_addr(rd_addr),
        .commit(commit), .rd_data(rd_data), .rd_valid(rd_valid));

    // ==========================================================
    // Helpers
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic read_chk(input logic [7:0] a, input logic [7:0] e);
        pbr_host_i.rd(a, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, e)
    endtask

    function automatic logic [10:0] exp_mv(input logic [5:0] c);
        return (c <= 6'h32) ? 11'(850 + 10 * c) : 11'(1350 + 25 * (c - 6'h32));
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        read_chk(ADDR_SW_CFG, 8'h00);
        read_chk(ADDR_BUCK, 8'hB5);
        `CHK(pulse_skip_en, 1'b1)
        `CHK(applied_code, 6'h35)
        `CHK(applied_mv, 11'h591)
    endtask

    task automatic t_regs();
        pbr_host_i.wr(ADDR_BUCK, 8'h00, 1'b0);
        #1;
        `CHK(wr_rejected, 1'b1)
        `CHK(monitor_blank, 1'b0)
        read_chk(ADDR_BUCK, 8'hB5);
        pbr_host_i.wr(ADDR_SW_CFG, 8'hFF, 1'b1);
        #1;
        `CHK(wr_rejected, 1'b0)
        read_chk(ADDR_SW_CFG, 8'h3F);
        pbr_host_i.wr(ADDR_BUCK, 8'h7F, 1'b1);
        read_chk(ADDR_BUCK, 8'h3F);
        `CHK(pulse_skip_en, 1'b0)
        read_chk(8'h20, 8'h00);
    endtask

    task automatic t_blank();
        int n;
        @(posedge clock);
        ov_raw <= 1'b1;
        settle(BLANK + 5);
        `CHK(ov_fault, 1'b1)
        pbr_host_i.wr(ADDR_BUCK, 8'h80, 1'b1);
        #1;
        n = 0;
        while (monitor_blank === 1'b1 && n < BLANK + 10) begin
            if (n == 10) `CHK(ov_fault, 1'b0)
            n++;
            settle(1);
        end
        `CHK(n, BLANK)
        settle(3);
        `CHK(ov_fault, 1'b1)
        `CHK(uv_fault, 1'b0)
        @(posedge clock);
        ov_raw <= 1'b0;
        uv_raw <= 1'b1;
        pbr_host_i.wr(ADDR_SW_CFG, 8'h00, 1'b1);
        #1;
        `CHK(monitor_blank, 1'b0)
        settle(4);
        `CHK(uv_fault, 1'b1)
        `CHK(ov_fault, 1'b0)
        pbr_host_i.wr(ADDR_BUCK, 8'h80, 1'b1);
        settle(2);
        `CHK(uv_fault, 1'b0)
        @(posedge clock);
        uv_raw <= 1'b0;
    endtask

    task automatic t_commit();
        logic [5:0] codes[4] = '{6'h00, 6'h32, 6'h33, 6'h3F};
        logic [5:0] prev;
        prev = 6'h35;
        foreach (codes[i]) begin
            pbr_host_i.wr(ADDR_BUCK, {2'b10, codes[i]}, 1'b1);
            settle(2);
            `CHK(applied_code, prev)
            pbr_host_i.cm();
            #1;
            `CHK(applied_code, codes[i])
            `CHK(applied_mv, exp_mv(codes[i]))
            `CHK(pulse_skip_en, 1'b1)
            prev = codes[i];
        end
    endtask

    task automatic t_switch();
        pbr_host_i.wr(ADDR_SW_CFG, 8'h2B, 1'b1);
        switch_en <= 3'h7;
        settle(4);
        `CHK(switch_on, 3'h7)
        `CHK(discharge_on, 3'h0)
        @(posedge clock);
        power_fail_out_n <= 1'b0;
        settle(4);
        `CHK(switch_on, 3'h2)
        `CHK(discharge_on, 3'h1)
        @(posedge clock);
        switch_en <= 3'h0;
        settle(4);
        `CHK(discharge_on, 3'h3)
        @(posedge clock);
        power_fail_out_n <= 1'b1;
        switch_en <= 3'h7;
        settle(4);
        `CHK(switch_on, 3'h7)
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_blank();
        t_commit();
        t_switch();
        test_done();
    end
endmodule // tb_pbr_regs
`default_nettype wire
